// [hdl/dbt_act.sv]
`timescale 1ns/1ns
module dbt_act (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	dbt_act_if.act link,
	input wire logic [10:0] periph_irq_i,
	input wire logic ext_request_n_i,
	output logic [10:0] cpu_irq_o,
	output logic [10:0] periph_clr_o
);
	import dbt_pkg::*;
	dbt_act_t a_reg;
	dbt_act_t a_next;
	logic int_sel;
	logic [10:0] sel_vec;
	logic sel_irq;
	logic ext_req;
	logic fall;

	assign int_sel = link.sel < `DBT_SRC_EXT;
	assign sel_vec = int_sel ? (11'h001 << link.sel) : 11'h000;
	assign sel_irq = |(periph_irq_i & sel_vec);
	assign ext_req = link.edge_mode ? a_reg.pend : ~a_reg.lvl;
	assign link.allowed = dbt_src_allowed(link.mode, link.sel);
	assign link.req = link.enable & link.allowed &
		(int_sel ? sel_irq :
		(link.sel == `DBT_SRC_EXT) ? ext_req : 1'b1);
	assign cpu_irq_o = a_reg.cpu;
	assign periph_clr_o = a_reg.clr;

	always_comb begin
		a_next = a_reg;
		a_next.s1 = ext_request_n_i;
		a_next.s2 = a_reg.s1;
		a_next.s3 = a_reg.s2;
		// Pin change only counts once two stages agree
		if (a_reg.s2 == a_reg.s3) begin
			a_next.lvl = a_reg.s3;
		end
		fall = a_reg.lvl & ~a_next.lvl;
		if (link.take | ~link.enable) begin
			a_next.pend = 1'b0;
		end
		// One edge held; further edges during a block merge
		if (fall) begin
			a_next.pend = 1'b1;
		end
		// Taken source hidden from the processor only when owned
		a_next.cpu = periph_irq_i &
			~((link.enable & link.owns) ? sel_vec : 11'h000);
		// Converter and serial flags clear by data access only
		a_next.clr = (link.take & link.owns &
			(link.sel >= `DBT_SRC_TMR_LO)) ? sel_vec : 11'h000;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			a_reg <= '0;
			a_reg.s1 <= 1'b1;
			a_reg.s2 <= 1'b1;
			a_reg.s3 <= 1'b1;
			a_reg.lvl <= 1'b1;
		end else begin
			a_reg <= a_next;
		end
	end
endmodule

// [hdl/dbt_act_if.sv]
`timescale 1ns/1ns
interface dbt_act_if;
	logic [3:0] sel;
	logic edge_mode;
	logic enable;
	logic owns;
	logic take;
	logic req;
	logic allowed;
	dbt_pkg::dbt_mode_t mode;
	modport eng(output sel, edge_mode, enable, owns, take, mode,
		input req, allowed);
	modport act(input sel, edge_mode, enable, owns, take, mode,
		output req, allowed);
endinterface

// [hdl/dbt_cfg.svh]
`ifndef DBT_CFG_SVH
`define DBT_CFG_SVH
// Register word indices on the plain register port
`define DBT_OFF_SRC 4'h0
`define DBT_OFF_DST 4'h1
`define DBT_OFF_SIZE 4'h2
`define DBT_OFF_BCNT 4'h3
`define DBT_OFF_CTRL 4'h4
`define DBT_OFF_STAT 4'h5
// Control word bit positions
`define DBT_B_FAE 0
`define DBT_B_BLOCK_MODE_ENABLE 1
`define DBT_B_XEN 2
`define DBT_B_EIE 3
`define DBT_B_OWN 4
`define DBT_B_AREA 5
`define DBT_B_WORD 6
`define DBT_B_SEN 7
`define DBT_B_SDIR 8
`define DBT_B_DEN 9
`define DBT_B_DDIR 10
`define DBT_B_EDGE 11
`define DBT_B_CHB 12
`define DBT_SEL_LO 16
`define DBT_SEL_HI 19
`define DBT_CTRL_MASK 32'h000F1FFF
`define DBT_CTRL_RESET 32'h00000000
// Activation source codes
`define DBT_NUM_IRQ 11
`define DBT_SRC_TMR_LO 4'h5
`define DBT_SRC_EXT 4'hB
`define DBT_SRC_AUTO 4'hC
`endif

// [hdl/dbt_pkg.sv]
package dbt_pkg;
`include "dbt_cfg.svh"
	typedef enum logic [1:0] {
		DBT_SHORT_A, DBT_SHORT_B, DBT_NORMAL, DBT_BLOCK
	} dbt_mode_t;
	typedef enum logic [2:0] {
		DBT_IDLE, DBT_READ, DBT_CAPT, DBT_WRITE, DBT_DEAD
	} dbt_state_t;
	typedef struct packed {
		dbt_state_t state;
		logic [23:0] src;
		logic [23:0] dst;
		logic [7:0] hold;
		logic [7:0] cnt;
		logic [15:0] bcnt;
		logic [31:0] ctrl;
		logic done;
		logic irq;
		logic rd;
		logic wr;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic [31:0] rdata;
	} dbt_eng_t;
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic pend;
		logic [10:0] cpu;
		logic [10:0] clr;
	} dbt_act_t;
	function automatic logic dbt_src_allowed(dbt_mode_t m, logic [3:0] s);
		logic intr;
		logic ext;
		logic r;
		intr = s < `DBT_SRC_EXT;
		ext = s == `DBT_SRC_EXT;
		r = 1'b0;
		unique case (m)
			DBT_SHORT_A: r = intr;
			DBT_SHORT_B: r = intr | ext;
			DBT_NORMAL: r = ext | (s == `DBT_SRC_AUTO);
			DBT_BLOCK: r = intr | ext;
		endcase
		return r;
	endfunction
endpackage

// [hdl/dbt_top.sv]
`timescale 1ns/1ns
`include "dbt_cfg.svh"
module dbt_top (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [10:0] periph_irq_i,
	input wire logic ext_request_n_i,
	output logic [10:0] cpu_irq_o,
	output logic [10:0] periph_clr_o,
	output logic [23:0] bus_addr_o,
	output logic bus_rd_o,
	output logic bus_wr_o,
	output logic bus_word_o,
	output logic [15:0] bus_wdata_o,
	input wire logic [15:0] bus_rdata_i,
	output logic xfer_end_irq_o
);
	import dbt_pkg::*;

	dbt_eng_t s_reg;
	dbt_eng_t s_next;
	dbt_act_if link();
	dbt_mode_t mode;
	logic [23:0] src_delta;
	logic [23:0] dst_delta;
	logic [8:0] blk_len;
	logic blk_end;
	logic xfer_last;

	////////////////////////////////////////////////////////////////////
	// Address arithmetic

	function automatic logic [23:0] step_of(logic en, logic dir,
		logic word);
		logic [23:0] sz;
		sz = word ? 24'h000002 : 24'h000001;
		if (!en) begin
			return 24'h000000;
		end
		return dir ? 24'(-sz) : sz;
	endfunction

	// Undo one whole block of steps; length 0 stands for 256
	function automatic logic [23:0] rewind(logic [23:0] a,
		logic [23:0] d, logic [8:0] len);
		logic [47:0] span;
		span = d * {15'h0000, len};
		return 24'(a - span[23:0]);
	endfunction

	assign src_delta = step_of(s_reg.ctrl[`DBT_B_SEN],
		s_reg.ctrl[`DBT_B_SDIR], s_reg.ctrl[`DBT_B_WORD]);
	assign dst_delta = step_of(s_reg.ctrl[`DBT_B_DEN],
		s_reg.ctrl[`DBT_B_DDIR], s_reg.ctrl[`DBT_B_WORD]);
	assign blk_len = (s_reg.hold == 8'h00) ? 9'h100 : {1'b0, s_reg.hold};
	assign blk_end = (s_reg.state == DBT_WRITE) && (s_reg.cnt == 8'h01);
	assign xfer_last = blk_end && (s_reg.bcnt == 16'h0001);

	////////////////////////////////////////////////////////////////////
	// Activation source selection

	always_comb begin
		if (s_reg.ctrl[`DBT_B_FAE]) begin
			mode = s_reg.ctrl[`DBT_B_BLOCK_MODE_ENABLE] ? DBT_BLOCK : DBT_NORMAL;
		end else begin
			mode = s_reg.ctrl[`DBT_B_CHB] ? DBT_SHORT_B : DBT_SHORT_A;
		end
	end

	assign link.mode = mode;
	assign link.sel = s_reg.ctrl[`DBT_SEL_HI:`DBT_SEL_LO];
	assign link.edge_mode = s_reg.ctrl[`DBT_B_EDGE];
	assign link.enable = s_reg.ctrl[`DBT_B_XEN];
	assign link.owns = s_reg.ctrl[`DBT_B_OWN];
	// Only the block mode is carried out here
	assign link.take = (s_reg.state == DBT_IDLE) && link.req &&
		(mode == DBT_BLOCK);

	dbt_act u_act (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.link(link.act),
		.periph_irq_i(periph_irq_i),
		.ext_request_n_i(ext_request_n_i),
		.cpu_irq_o(cpu_irq_o),
		.periph_clr_o(periph_clr_o)
	);

	////////////////////////////////////////////////////////////////////
	// Registers and transfer engine

	always_comb begin
		s_next = s_reg;
		s_next.rd = 1'b0;
		s_next.wr = 1'b0;
		s_next.rdata = 32'h00000000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`DBT_OFF_SRC: s_next.rdata = {8'h00, s_reg.src};
				`DBT_OFF_DST: s_next.rdata = {8'h00, s_reg.dst};
				`DBT_OFF_SIZE: s_next.rdata = {16'h0000, s_reg.hold, s_reg.cnt};
				`DBT_OFF_BCNT: s_next.rdata = {16'h0000, s_reg.bcnt};
				`DBT_OFF_CTRL: s_next.rdata = s_reg.ctrl;
				`DBT_OFF_STAT: s_next.rdata = {29'h00000000, link.allowed,
					s_reg.done, s_reg.state != DBT_IDLE};
				default: s_next.rdata = 32'h00000000;
			endcase
		end
		// Software loads all counts; engine updates follow and win
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`DBT_OFF_SRC: s_next.src = reg_wdata_i[23:0];
				`DBT_OFF_DST: s_next.dst = reg_wdata_i[23:0];
				`DBT_OFF_SIZE: begin
					s_next.hold = reg_wdata_i[15:8];
					s_next.cnt = reg_wdata_i[7:0];
				end
				`DBT_OFF_BCNT: s_next.bcnt = reg_wdata_i[15:0];
				`DBT_OFF_CTRL: begin
					s_next.ctrl = reg_wdata_i & `DBT_CTRL_MASK;
					if (reg_wdata_i[`DBT_B_XEN]) begin
						s_next.done = 1'b0;
					end
				end
				default: ;
			endcase
		end
		unique case (s_reg.state)
			DBT_IDLE: begin
				if (link.take) begin
					s_next.state = DBT_READ;
					s_next.rd = 1'b1;
					s_next.addr = s_reg.src;
				end
			end
			DBT_READ: begin
				s_next.state = DBT_CAPT;
			end
			DBT_CAPT: begin
				// Read data stand only now, one cycle after the strobe
				s_next.state = DBT_WRITE;
				s_next.wr = 1'b1;
				s_next.addr = s_reg.dst;
				s_next.wdata = s_reg.ctrl[`DBT_B_WORD] ? bus_rdata_i :
					{8'h00, bus_rdata_i[7:0]};
			end
			DBT_WRITE: begin
				s_next.src = 24'(s_reg.src + src_delta);
				s_next.dst = 24'(s_reg.dst + dst_delta);
				if (blk_end) begin
					s_next.cnt = s_reg.hold;
					if (s_reg.ctrl[`DBT_B_AREA]) begin
						s_next.src = rewind(s_next.src, src_delta, blk_len);
					end else begin
						s_next.dst = rewind(s_next.dst, dst_delta, blk_len);
					end
					s_next.bcnt = 16'(s_reg.bcnt - 16'h0001);
					if (xfer_last) begin
						s_next.ctrl[`DBT_B_XEN] = 1'b0;
						s_next.done = 1'b1;
					end
					// Bus released after a dead state; level or pending
					// requests start the next block from idle
					s_next.state = DBT_DEAD;
				end else begin
					s_next.cnt = 8'(s_reg.cnt - 8'h01);
					s_next.state = DBT_READ;
					s_next.rd = 1'b1;
					s_next.addr = s_next.src;
				end
			end
			DBT_DEAD: begin
				s_next.state = DBT_IDLE;
			end
			default: s_next.state = DBT_IDLE;
		endcase
		s_next.irq = s_next.done & s_next.ctrl[`DBT_B_EIE];
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_reg <= '0;
			s_reg.ctrl <= `DBT_CTRL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata_o = s_reg.rdata;
	assign bus_addr_o = s_reg.addr;
	assign bus_rd_o = s_reg.rd;
	assign bus_wr_o = s_reg.wr;
	assign bus_word_o = s_reg.ctrl[`DBT_B_WORD];
	assign bus_wdata_o = s_reg.wdata;
	assign xfer_end_irq_o = s_reg.irq;

	////////////////////////////////////////////////////////////////////
	// Checks

	// Block start of the area address; invalid once software writes mid-run
	logic [23:0] chk_start;
	logic chk_dirty;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			chk_start <= 24'h000000;
			chk_dirty <= 1'b0;
		end else if (link.take) begin
			chk_start <= s_reg.ctrl[`DBT_B_AREA] ? s_reg.src : s_reg.dst;
			chk_dirty <= 1'b0;
		end else if (reg_wr_i) begin
			chk_dirty <= 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	property p_start_mode;
		link.take |-> s_reg.ctrl[`DBT_B_FAE] && s_reg.ctrl[`DBT_B_BLOCK_MODE_ENABLE]
			&& s_reg.ctrl[`DBT_B_XEN];
	endproperty
	a_start_mode: assert property (p_start_mode)
		else $error("start outside block mode");

	property p_read_addr;
		link.take |=> bus_rd_o && bus_addr_o == $past(s_reg.src)
			##2 bus_wr_o && bus_addr_o == $past(s_reg.dst, 3);
	endproperty
	a_read_addr: assert property (p_read_addr)
		else $error("read or write address wrong");

	property p_src_step;
		(s_reg.state == DBT_WRITE && !blk_end && !reg_wr_i) |=>
			s_reg.src == 24'($past(s_reg.src) + $past(src_delta));
	endproperty
	a_src_step: assert property (p_src_step)
		else $error("source step wrong");

	property p_burst;
		(s_reg.state == DBT_WRITE && !blk_end) |=> bus_rd_o ##2 bus_wr_o;
	endproperty
	a_burst: assert property (p_burst)
		else $error("burst broke inside block");

	property p_area_back;
		(blk_end && !chk_dirty && !reg_wr_i && !s_reg.ctrl[`DBT_B_AREA])
			|=> s_reg.dst == chk_start;
	endproperty
	a_area_back: assert property (p_area_back)
		else $error("block area not restored");

	property p_last;
		(xfer_last && !reg_wr_i) |=> !s_reg.ctrl[`DBT_B_XEN] &&
			s_reg.bcnt == 16'h0000 && s_reg.done;
	endproperty
	a_last: assert property (p_last)
		else $error("transfer did not stop");

	property p_end_irq;
		(xfer_last && !reg_wr_i && s_reg.ctrl[`DBT_B_EIE]) |=>
			xfer_end_irq_o [*2];
	endproperty
	a_end_irq: assert property (p_end_irq)
		else $error("end interrupt missing");

	property p_dead;
		blk_end |=> s_reg.state == DBT_DEAD && !bus_rd_o && !bus_wr_o
			##1 s_reg.state == DBT_IDLE;
	endproperty
	a_dead: assert property (p_dead)
		else $error("dead state missing");

	property p_gate;
		!link.enable |=> cpu_irq_o == $past(periph_irq_i);
	endproperty
	a_gate: assert property (p_gate)
		else $error("request held back while disabled");

	property p_no_auto;
		(mode == DBT_BLOCK && link.sel == `DBT_SRC_AUTO) |-> !link.req;
	endproperty
	a_no_auto: assert property (p_no_auto)
		else $error("auto request in block mode");

	property p_clear_flag;
		(link.take && link.owns && link.sel >= `DBT_SRC_TMR_LO &&
			link.sel < `DBT_SRC_EXT) |=> periph_clr_o != 11'h000;
	endproperty
	a_clear_flag: assert property (p_clear_flag)
		else $error("owned flag not cleared");

	property p_clr_pulse;
		periph_clr_o != 11'h000 |=> periph_clr_o == 11'h000;
	endproperty
	a_clr_pulse: assert property (p_clr_pulse)
		else $error("flag clear pulse too long");

	property p_reload;
		(blk_end && !reg_wr_i) |=> s_reg.cnt == $past(s_reg.hold);
	endproperty
	a_reload: assert property (p_reload)
		else $error("size counter not reloaded");

	property p_block_count;
		(blk_end && !xfer_last && !reg_wr_i) |=> s_reg.ctrl[`DBT_B_XEN] &&
			s_reg.bcnt == 16'($past(s_reg.bcnt) - 16'h0001);
	endproperty
	a_block_count: assert property (p_block_count)
		else $error("block count step wrong");

	c_block_end: cover property (blk_end && !xfer_last);
	c_xfer_end: cover property (xfer_last ##2 link.take);
	c_edge_start: cover property (link.take && link.edge_mode &&
		link.sel == `DBT_SRC_EXT);
	c_timer_start: cover property (link.take && link.owns);
endmodule

// [tb/dbt_far_model.sv]
`timescale 1ns/1ns
module dbt_far_model #(
	parameter logic [23:0] CONV_DATA_ADDR = 24'hFFFF00
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic [23:0] bus_addr_i,
	input wire logic bus_rd_i,
	input wire logic [10:0] periph_clr_i,
	input wire logic [10:0] raise_i,
	output logic [15:0] bus_rdata_o,
	output logic [10:0] periph_irq_o
);
	typedef struct packed {
		logic [15:0] rdata;
		logic [10:0] irq;
	} dbt_far_t;
	dbt_far_t far_reg;
	dbt_far_t far_next;
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		far_next = far_reg;
		// Idle bus toggles so stale data never looks valid
		far_next.rdata = ~far_reg.rdata;
		if (bus_rd_i) begin
			far_next.rdata = bus_addr_i[15:0] ^ 16'hA5C3;
		end
		far_next.irq = (far_reg.irq & ~periph_clr_i) | raise_i;
		if (bus_rd_i && bus_addr_i == CONV_DATA_ADDR) begin
			far_next.irq[0] = 1'b0;
		end
	end
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			far_reg <= '0;
		end else begin
			far_reg <= far_next;
		end
	end
	assign bus_rdata_o = far_reg.rdata;
	assign periph_irq_o = far_reg.irq;
endmodule

// [tb/dbt_top_test.sv]
`timescale 1ns/1ns
`include "dbt_cfg.svh"
module dbt_top_test;
	typedef struct {
		logic [3:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} dbt_row_t;
	logic sys_clk_i = 0, arst_n_i = 0, reg_wr = 0, reg_rd = 0, ext_n = 1;
	logic [3:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0, reg_rdata;
	logic [10:0] raise = '0, periph_irq, cpu_irq, periph_clr;
	logic [23:0] bus_addr;
	logic bus_rd, bus_wr, bus_word, end_irq;
	logic [15:0] bus_wdata, bus_rdata;
	logic [23:0] wa[$];
	logic [15:0] wd[$];
	int wt[$], rt[$], cyc = 0, mismatches = 0, num_checks = 0;
	dbt_row_t rows[6] = '{'{4'h0, 32'h00ABCDEF, 32'h00ABCDEF},
		'{4'h1, 32'hFF123456, 32'h00123456},
		'{4'h2, 32'hFFFF0201, 32'h00000201},
		'{4'h3, 32'hFFFF1234, 32'h00001234},
		'{4'h4, 32'hFFF0E3F8, 32'h000003F8},
		'{4'h6, 32'hFFFFFFFF, 32'h00000000}};
	logic [31:0] modes[8] = '{32'h000C0005, 32'h4, 32'h000C0007, 32'h0,
		32'h000B1004, 32'h4, 32'h000B0004, 32'h0};
	always #5 sys_clk_i = ~sys_clk_i;
	dbt_top dut_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.periph_irq_i(periph_irq), .ext_request_n_i(ext_n),
		.cpu_irq_o(cpu_irq), .periph_clr_o(periph_clr),
		.bus_addr_o(bus_addr), .bus_rd_o(bus_rd), .bus_wr_o(bus_wr),
		.bus_word_o(bus_word), .bus_wdata_o(bus_wdata),
		.bus_rdata_i(bus_rdata), .xfer_end_irq_o(end_irq));
	dbt_far_model far_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
		.bus_addr_i(bus_addr), .bus_rd_i(bus_rd), .periph_clr_i(periph_clr),
		.raise_i(raise), .bus_rdata_o(bus_rdata), .periph_irq_o(periph_irq));
	////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk_i) begin
		cyc++;
		if (bus_wr === 1'b1) begin
			wa.push_back(bus_addr);
			wd.push_back(bus_wdata);
			wt.push_back(cyc);
		end
		if (bus_rd === 1'b1) begin
			rt.push_back(cyc);
		end
	end
	function automatic logic [15:0] pat(input logic [23:0] a);
		return a[15:0] ^ 16'hA5C3;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	task automatic wait_wr(input int n);
		for (int i = 0; i < 300 && wa.size() < n; i++) @(posedge sys_clk_i);
		repeat (4) @(posedge sys_clk_i);
		chk(wa.size(), n);
	endtask
	task automatic pulse(input int b);
		@(posedge sys_clk_i);
		raise[b] <= 1'b1;
		@(posedge sys_clk_i);
		raise[b] <= 1'b0;
	endtask
	task close_out;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Whole run needs a few hundred cycles; this is a generous ceiling
	initial begin
		#200000;
		mismatches++;
		close_out;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		rchk(`DBT_OFF_CTRL, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rchk(rows[i].a, rows[i].e);
		end
		// Two byte blocks of two, timer source, area on destination
		wr(`DBT_OFF_SRC, 32'h100);
		wr(`DBT_OFF_DST, 32'h200);
		wr(`DBT_OFF_SIZE, 32'h0202);
		wr(`DBT_OFF_BCNT, 32'h2);
		wr(`DBT_OFF_CTRL, 32'h0005029F);
		// Second request lands while the first block is still running
		pulse(5);
		pulse(5);
		wait_wr(4);
		chk(rt.size(), 4);
		for (int k = 0; k < 4; k++) begin
			chk({8'h00, wa[k]}, 32'h200 + k % 2);
			chk(wd[k], {8'h00, pat(24'h100 + k) & 16'h00FF});
		end
		chk(rt[2] - wt[1], 3);
		chk(end_irq, 1'b1);
		rchk(`DBT_OFF_SRC, 32'h104);
		rchk(`DBT_OFF_DST, 32'h200);
		rchk(`DBT_OFF_SIZE, 32'h0202);
		rchk(`DBT_OFF_BCNT, 32'h0);
		rchk(`DBT_OFF_CTRL, 32'h0005029B);
		rchk(`DBT_OFF_STAT, 32'h6);
		// Enable now clear: flag must bypass to the processor
		pulse(5);
		repeat (4) @(posedge sys_clk_i);
		chk(cpu_irq[5], 1'b1);
		chk(periph_irq[5], 1'b1);
		chk(wa.size(), 4);
		// Pin on falling edge, word units, source stepping down
		wr(`DBT_OFF_SRC, 32'h300);
		wr(`DBT_OFF_DST, 32'h400);
		wr(`DBT_OFF_SIZE, 32'h0101);
		wr(`DBT_OFF_BCNT, 32'h2);
		wr(`DBT_OFF_CTRL, 32'h000B09C7);
		ext_n <= 1'b0;
		wait_wr(5);
		repeat (20) @(posedge sys_clk_i);
		chk(wa.size(), 5);
		ext_n <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		ext_n <= 1'b0;
		wait_wr(6);
		ext_n <= 1'b1;
		chk({8'h00, wa[5]}, 32'h400);
		chk(wd[4], pat(24'h300));
		chk(wd[5], pat(24'h2FE));
		chk(bus_word, 1'b1);
		chk(end_irq, 1'b0);
		rchk(`DBT_OFF_SRC, 32'h2FC);
		// Converter source: its flag clears only by reading its data word
		wr(`DBT_OFF_SRC, 32'hFFFF00);
		wr(`DBT_OFF_DST, 32'h500);
		wr(`DBT_OFF_BCNT, 32'h2);
		wr(`DBT_OFF_CTRL, 32'h00000217);
		pulse(0);
		wait_wr(7);
		chk(periph_irq[0], 1'b0);
		chk(wd[6], {8'h00, pat(24'hFFFF00) & 16'h00FF});
		rchk(`DBT_OFF_BCNT, 32'h1);
		// Low level on the pin: blocks repeat until it returns high
		wr(`DBT_OFF_SRC, 32'h600);
		wr(`DBT_OFF_BCNT, 32'h4);
		wr(`DBT_OFF_CTRL, 32'h000B0087);
		ext_n <= 1'b0;
		for (int i = 0; i < 300 && wa.size() < 9; i++) @(posedge sys_clk_i);
		ext_n <= 1'b1;
		repeat (20) @(posedge sys_clk_i);
		chk(wa.size(), 10);
		chk({8'h00, wa[9]}, 32'h500);
		rchk(`DBT_OFF_BCNT, 32'h1);
		// Reset in mid-run: bus and counts return to zero
		arst_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		chk(bus_addr, 24'h000000);
		rchk(`DBT_OFF_BCNT, 32'h0);
		// Normal mode, block with auto, short A and B: nothing moves
		for (int i = 0; i < 8; i += 2) begin
			wr(`DBT_OFF_CTRL, modes[i]);
			repeat (10) @(posedge sys_clk_i);
			rchk(`DBT_OFF_STAT, modes[i + 1]);
		end
		chk(wa.size(), 10);
		close_out;
	end
endmodule
